// ===== temp_conv_cond.sv
// conversion scheduling and result conditioning with a classic wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

// Summary of operation
// - codes 6h..Ah give 4..64 conversions/s
// - codes Bh..Fh give one conversion/s
// - dynamic averaging stretches diode measurement time
// - dynamic averaging on at reset, can disable
// - rate code selects averaging factor
// - one-shot uses current rate's factor
// - filter field: off, level 1, level 2
// - level 1 averages 4, level 2 eight
// - filter only channels 1,2 unpaired
// - filter fed with averaged 11-bit result
// - first result preloads whole history
// - filtered value stored as visible result
// - auto beta applied and reported each conversion
// - manual beta uses software field
// - no beta on unsupported channels
// - beta code 0..Eh steps, Fh diode
// - standby: one cycle per request
// - active: continuous, one-shot ignored
module temp_conv_cond #(
    parameter int TICK_CYCLES = `TCC_TICK_CYCLES,
    parameter bit FIVE_CHANNEL = 1'b0
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic conv_start,
    output logic [1:0] meas_chan,
    output logic [2:0] meas_factor,
    output logic [3:0] meas_beta,
    input wire logic [3:0] beta_found,
    input wire logic adc_valid,
    input wire logic [10:0] adc_result,
    output logic [3:0][10:0] result,
    output logic busy,
    output logic active
);

    localparam logic [3:0] BETA_OK = FIVE_CHANNEL ? `TCC_BETA_OK_5CH : `TCC_BETA_OK_4CH;
    localparam logic [18:0] TICK_LAST = 19'(TICK_CYCLES - 1);

    tcc_pkg::core_state_t q;
    tcc_pkg::core_state_t n;
    wire logic [1:0][10:0] filt_out;
    wire logic [1:0] filt_valid;
    wire logic [1:0][1:0] filt_level;

    // ======================================================
    // rate decode
    function automatic logic [10:0] period_len(input logic [3:0] code);
        if (code <= `TCC_RATE_MAXCODE) begin
            period_len = `TCC_PERIOD_MAX >> code;
        end else begin
            period_len = `TCC_RATE_1PS_LEN;
        end
    endfunction : period_len

    function automatic tcc_pkg::avg_factor_t factor_of(input logic [3:0] code, input logic off);
        if (code == `TCC_RATE_HALF) begin
            factor_of = tcc_pkg::fac_half;
        end else if (off) begin
            factor_of = tcc_pkg::fac_1x;
        end else begin
            unique case (code)
                4'h6: factor_of = tcc_pkg::fac_8x;
                4'h7: factor_of = tcc_pkg::fac_4x;
                4'h8: factor_of = tcc_pkg::fac_2x;
                4'h9: factor_of = tcc_pkg::fac_1x;
                default: factor_of = tcc_pkg::fac_16x;
            endcase
        end
    endfunction : factor_of

    // ======================================================
    // register view
    function automatic logic [31:0] reg_view(input tcc_pkg::core_state_t s, input logic [7:0] adr);
        reg_view = 32'h0000_0000;
        unique case (adr)
            `TCC_ADR_CTRL: begin
                reg_view[`TCC_CTRL_RUN] = s.run;
                reg_view[`TCC_CTRL_DYN_OFF] = s.dyn_off;
                reg_view[`TCC_CTRL_FILT0 +: 2] = s.filt_lvl[0];
                reg_view[`TCC_CTRL_FILT1 +: 2] = s.filt_lvl[1];
                reg_view[`TCC_CTRL_PAIR0] = s.paired[0];
                reg_view[`TCC_CTRL_PAIR1] = s.paired[1];
            end
            `TCC_ADR_RATE: reg_view = {28'h0000000, s.rate};
            `TCC_ADR_BETA: begin
                for (int i = 0; i < `TCC_NUM_CH; i++) begin
                    reg_view[i*`TCC_BETA_STRIDE +: `TCC_BETA_STRIDE] = {s.beta_auto[i], s.beta_code[i]};
                end
            end
            `TCC_ADR_STAT: begin
                reg_view[`TCC_STAT_BUSY] = s.busy;
                reg_view[`TCC_STAT_RUN] = s.run;
                reg_view[`TCC_STAT_FACT +: 3] = s.meas_factor;
                reg_view[`TCC_STAT_CHAN +: 2] = s.chan;
            end
            `TCC_ADR_RES0: reg_view = {21'h000000, s.result[0]};
            `TCC_ADR_RES1: reg_view = {21'h000000, s.result[1]};
            `TCC_ADR_RES2: reg_view = {21'h000000, s.result[2]};
            `TCC_ADR_RES3: reg_view = {21'h000000, s.result[3]};
            default: reg_view = 32'h0000_0000;
        endcase
    endfunction : reg_view

    // ======================================================
    // filters for external channels 1 and 2
    generate
        for (genvar c = 0; c < 2; c++) begin : g_filt
            assign filt_level[c] = q.paired[c] ? 2'b00 : q.filt_lvl[c];
            assign filt_valid[c] = (q.state == tcc_pkg::s_wait) && adc_valid && (q.chan == 2'(c));
            run_avg_filter u_filt (
                .clock(clock),
                .resetn(resetn),
                .in_valid(filt_valid[c]),
                .in_data(adc_result),
                .level(filt_level[c]),
                .out_data(filt_out[c])
            );
        end
    endgenerate

    // ======================================================
    // next state
    always_comb begin
        logic hit;
        logic start_req;
        logic [31:0] mask;
        logic [31:0] wval;
        hit = 1'b0;
        start_req = 1'b0;
        mask = 32'h0000_0000;
        wval = 32'h0000_0000;
        n = q;
        n.ack = 1'b0;
        n.conv_start = 1'b0;

        // period timer
        if (q.base_cnt == TICK_LAST) begin
            n.base_cnt = 19'h00000;
            if (q.per_cnt >= period_len(q.rate) - 11'h001) begin
                n.per_cnt = 11'h000;
                start_req = q.run;
            end else begin
                n.per_cnt = q.per_cnt + 11'h001;
            end
        end else begin
            n.base_cnt = q.base_cnt + 19'h00001;
        end

        // bus access
        hit = wb_cyc_i && wb_stb_i && !q.ack;
        if (hit) begin
            n.ack = 1'b1;
            n.rdat = reg_view(q, wb_adr_i);
            for (int b = 0; b < 4; b++) begin
                mask[b*8 +: 8] = {8{wb_sel_i[b]}};
            end
            wval = (reg_view(q, wb_adr_i) & ~mask) | (wb_dat_i & mask);
            if (wb_we_i) begin
                unique case (wb_adr_i)
                    `TCC_ADR_CTRL: begin
                        n.run = wval[`TCC_CTRL_RUN];
                        n.dyn_off = wval[`TCC_CTRL_DYN_OFF];
                        n.filt_lvl[0] = wval[`TCC_CTRL_FILT0 +: 2];
                        n.filt_lvl[1] = wval[`TCC_CTRL_FILT1 +: 2];
                        n.paired[0] = wval[`TCC_CTRL_PAIR0];
                        n.paired[1] = wval[`TCC_CTRL_PAIR1];
                    end
                    `TCC_ADR_RATE: n.rate = wval[3:0];
                    `TCC_ADR_SHOT: begin
                        if (!q.run && wb_sel_i[0]) begin
                            n.shot_pend = 1'b1;
                        end
                    end
                    `TCC_ADR_BETA: begin
                        for (int i = 0; i < `TCC_NUM_CH; i++) begin
                            if (BETA_OK[i]) begin
                                n.beta_auto[i] = wval[i*`TCC_BETA_STRIDE + `TCC_BETA_AUTO];
                                n.beta_code[i] = wval[i*`TCC_BETA_STRIDE +: 4];
                            end
                        end
                    end
                    default: n.ack = 1'b1;
                endcase
            end
        end

        // conversion sequencer
        unique case (q.state)
            tcc_pkg::s_idle: begin
                if (start_req || (n.shot_pend && !q.run)) begin
                    n.shot_pend = 1'b0;
                    n.chan = 2'b00;
                    n.state = tcc_pkg::s_launch;
                end
            end
            tcc_pkg::s_launch: begin
                n.conv_start = 1'b1;
                n.meas_chan = q.chan;
                n.meas_factor = factor_of(q.rate, q.dyn_off);
                if (q.beta_auto[q.chan] && BETA_OK[q.chan]) begin
                    n.meas_beta = beta_found;
                    n.beta_code[q.chan] = beta_found;
                end else if (BETA_OK[q.chan]) begin
                    n.meas_beta = q.beta_code[q.chan];
                end else begin
                    n.meas_beta = `TCC_BETA_DIODE;
                end
                n.state = tcc_pkg::s_wait;
            end
            tcc_pkg::s_wait: begin
                if (adc_valid) begin
                    n.raw = adc_result;
                    n.state = tcc_pkg::s_store;
                end
            end
            tcc_pkg::s_store: begin
                if (q.chan < 2'b10) begin
                    n.result[q.chan] = filt_out[q.chan[0]];
                end else begin
                    n.result[q.chan] = q.raw;
                end
                if (q.chan == 2'b11) begin
                    n.state = tcc_pkg::s_idle;
                end else begin
                    n.chan = q.chan + 2'b01;
                    n.state = tcc_pkg::s_launch;
                end
            end
        endcase
        n.busy = (n.state != tcc_pkg::s_idle);
    end

    // ======================================================
    // state register
    always_ff @(posedge clock) begin
        if (!resetn) begin
            q <= '0;
            q.rate <= `TCC_RATE_RESET;
            q.dyn_off <= 1'b0;
            q.filt_lvl <= '0;
            q.paired <= '0;
            q.run <= 1'b0;
            q.beta_auto <= BETA_OK;
            q.beta_code <= {4{`TCC_BETA_DIODE}};
            q.meas_beta <= `TCC_BETA_DIODE;
            q.state <= tcc_pkg::s_idle;
        end else begin
            q <= n;
        end
    end

    // ======================================================
    // outputs
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    assign conv_start = q.conv_start;
    assign meas_chan = q.meas_chan;
    assign meas_factor = q.meas_factor;
    assign meas_beta = q.meas_beta;
    assign result = q.result;
    assign busy = q.busy;
    assign active = q.run;

endmodule : temp_conv_cond

`default_nettype wire

// ===== tcc_consts.svh
// register map, reset values and timing counts of the conversion/conditioning block
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH

`define TCC_ADR_CTRL 8'h00
`define TCC_ADR_RATE 8'h04
`define TCC_ADR_SHOT 8'h08
`define TCC_ADR_BETA 8'h0C
`define TCC_ADR_STAT 8'h10
`define TCC_ADR_RES0 8'h14
`define TCC_ADR_RES1 8'h18
`define TCC_ADR_RES2 8'h1C
`define TCC_ADR_RES3 8'h20

`define TCC_CTRL_RUN 0
`define TCC_CTRL_DYN_OFF 1
`define TCC_CTRL_FILT0 2
`define TCC_CTRL_FILT1 4
`define TCC_CTRL_PAIR0 6
`define TCC_CTRL_PAIR1 7
`define TCC_STAT_BUSY 0
`define TCC_STAT_RUN 1
`define TCC_STAT_FACT 2
`define TCC_STAT_CHAN 5
`define TCC_BETA_STRIDE 5
`define TCC_BETA_AUTO 4

`define TCC_RATE_RESET 4'h6
`define TCC_RATE_MAXCODE 4'hA
`define TCC_RATE_HALF 4'hA
`define TCC_RATE_1PS_LEN 11'h040
`define TCC_PERIOD_MAX 11'h400
`define TCC_BETA_DIODE 4'hF
`define TCC_BETA_OK_4CH 4'h9
`define TCC_BETA_OK_5CH 4'h3

`define TCC_CLK_NS 50
`define TCC_TICK_NS 15625000
`define TCC_TICK_CYCLES (`TCC_TICK_NS / `TCC_CLK_NS)
`define TCC_NUM_CH 4

`endif

// ===== tcc_pkg.sv
// types shared by the conversion/conditioning block
`default_nettype none

package tcc_pkg;

    typedef enum logic [2:0] {fac_half, fac_1x, fac_2x, fac_4x, fac_8x, fac_16x} avg_factor_t;

    typedef enum logic [1:0] {s_idle, s_launch, s_wait, s_store} seq_state_t;

    typedef struct packed {
        logic [7:0][10:0] hist;
        logic primed;
        logic [1:0] lvl;
        logic [10:0] out;
    } filt_state_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic run;
        logic dyn_off;
        logic [1:0][1:0] filt_lvl;
        logic [1:0] paired;
        logic [3:0] rate;
        logic [3:0] beta_auto;
        logic [3:0][3:0] beta_code;
        logic [3:0][10:0] result;
        logic [18:0] base_cnt;
        logic [10:0] per_cnt;
        seq_state_t state;
        logic [1:0] chan;
        logic shot_pend;
        logic [10:0] raw;
        logic conv_start;
        logic [1:0] meas_chan;
        logic [2:0] meas_factor;
        logic [3:0] meas_beta;
        logic busy;
    } core_state_t;

endpackage : tcc_pkg

`default_nettype wire

// ===== run_avg_filter.sv
// running-average filter for one external diode channel
`timescale 1ns/1ps
`default_nettype none

module run_avg_filter (
    input wire logic clock,
    input wire logic resetn,
    input wire logic in_valid,
    input wire logic [10:0] in_data,
    input wire logic [1:0] level,
    output logic [10:0] out_data
);

    tcc_pkg::filt_state_t q;
    tcc_pkg::filt_state_t n;
    logic [13:0] sum4;
    logic [13:0] sum8;

    // ======================================================
    // history update and average
    always_comb begin
        n = q;
        sum4 = 14'h0000;
        sum8 = 14'h0000;
        if (in_valid) begin
            if (!q.primed || (q.lvl != level)) begin
                for (int i = 0; i < 8; i++) begin
                    n.hist[i] = in_data;
                end
                n.primed = 1'b1;
                n.lvl = level;
            end else begin
                n.hist = {q.hist[6:0], in_data};
            end
            for (int i = 0; i < 8; i++) begin
                if (i < 4) begin
                    sum4 = sum4 + {3'b000, n.hist[i]};
                end
                sum8 = sum8 + {3'b000, n.hist[i]};
            end
            unique case (level)
                2'b00: n.out = in_data;
                2'b01, 2'b10: n.out = sum4[12:2];
                2'b11: n.out = sum8[13:3];
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign out_data = q.out;

endmodule : run_avg_filter

`default_nettype wire

// ===== tcc_monitor.sv
// assertion checker for the conversion and conditioning block
`timescale 1ns/1ps
`default_nettype none

module tcc_monitor #(
    parameter bit FIVE_CHANNEL = 1'b0
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic conv_start,
    input wire logic [1:0] meas_chan,
    input wire logic [2:0] meas_factor,
    input wire logic [3:0] meas_beta,
    input wire logic adc_valid,
    input wire logic [3:0][10:0] result,
    input wire logic busy
);
    // ==========================================
    // sequences
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ans;
        ##1 wb_ack_o ##1 !wb_ack_o;
    endsequence
    sequence s_store;
        ##1 !conv_start [*2];
    endsequence
    // ==========================================
    // properties
    bus_answer_a: assert property (s_req |-> s_ans)
        else $error("bus answer late or long");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("start is not a pulse");
    start_busy_a: assert property (conv_start |-> busy)
        else $error("start outside a cycle");
    chan_order_a: assert property (conv_start && meas_chan != 2'h0 |-> $past(meas_chan) == meas_chan - 2'h1)
        else $error("channel order broken");
    cycle_end_a: assert property ($fell(busy) |-> meas_chan == 2'h3)
        else $error("cycle ended early");
    meas_hold_a: assert property ($changed({meas_chan, meas_factor, meas_beta}) |-> conv_start)
        else $error("measurement setup moved");
    store_gap_a: assert property (adc_valid |-> s_store)
        else $error("relaunch before store");
    beta_off_a: assert property (conv_start && (FIVE_CHANNEL ? meas_chan >= 2'h2 : (meas_chan == 2'h1 || meas_chan == 2'h2)) |-> meas_beta == 4'hF)
        else $error("beta on unsupported channel");
    result_cause_a: assert property ($changed(result) |-> $past(adc_valid, 2))
        else $error("result moved without data");
endmodule : tcc_monitor

bind temp_conv_cond tcc_monitor #(.FIVE_CHANNEL(FIVE_CHANNEL)) u_monitor (
    .clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .conv_start(conv_start), .meas_chan(meas_chan), .meas_factor(meas_factor), .meas_beta(meas_beta),
    .adc_valid(adc_valid), .result(result), .busy(busy)
);

`default_nettype wire

// ===== diode_adc_model.sv
// converter and diode front end seen by the block
`timescale 1ns/1ps
`default_nettype none

module diode_adc_model #(
    parameter int DELAY = 2
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic conv_start,
    input wire logic [10:0] value,
    output logic adc_valid,
    output logic [10:0] adc_result,
    output logic [3:0] beta_found
);
    int cnt;
    assign beta_found = 4'h5;
    // ==========================================
    // result after a fixed delay, inverted on each clock that does not load it
    always @(posedge clock) begin
        adc_valid <= 1'b0;
        adc_result <= ~adc_result;
        if (!resetn) begin
            cnt <= 0;
            adc_result <= 11'h000;
        end else if (conv_start) begin
            cnt <= DELAY;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                adc_valid <= 1'b1;
                adc_result <= value;
            end
        end
    end
endmodule : diode_adc_model

`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the conversion and conditioning block
`timescale 1ns/1ps
`default_nettype none
`include "tcc_consts.svh"

module tb_top;
    localparam int TICK = 8;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [10:0] value = 11'h000;
    logic [31:0] rd;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, conv_start, adc_valid, busy, active;
    logic [1:0] meas_chan;
    logic [2:0] meas_factor;
    logic [3:0] meas_beta, beta_found;
    logic [10:0] adc_result;
    logic [3:0][10:0] result;
    logic [3:0][3:0] seen_beta;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int n_starts = 0;

    temp_conv_cond #(.TICK_CYCLES(TICK), .FIVE_CHANNEL(1'b0)) DUT (
        .clock(clock), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_start(conv_start),
        .meas_chan(meas_chan), .meas_factor(meas_factor), .meas_beta(meas_beta), .beta_found(beta_found),
        .adc_valid(adc_valid), .adc_result(adc_result), .result(result), .busy(busy), .active(active)
    );
    diode_adc_model #(.DELAY(2)) u_adc (
        .clock(clock), .resetn(resetn), .conv_start(conv_start), .value(value),
        .adc_valid(adc_valid), .adc_result(adc_result), .beta_found(beta_found)
    );

    // ==========================================
    // clock, watchdog and helpers
    always #25 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (conv_start === 1'b1) begin
            n_starts <= n_starts + 1;
            seen_beta[meas_chan] <= meas_beta;
        end
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            give_verdict();
        end
    end
    task give_verdict;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clock); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task shot(input logic [10:0] v);
        value <= v;
        n_starts = 0;
        wb(1'b1, `TCC_ADR_SHOT, 32'h0000_0001);
        while (busy !== 1'b1) @(posedge clock);
        while (busy !== 1'b0) @(posedge clock);
        repeat (2) @(posedge clock);
        check(n_starts, 32'h0000_0004);
    endtask : shot
    task wait_ch0;
        do @(posedge clock); while (!(conv_start === 1'b1 && meas_chan === 2'h0));
    endtask : wait_ch0

    // ==========================================
    // scenarios
    task t_reset;
        wb(1'b0, `TCC_ADR_CTRL, 32'h0);
        check(rd, 32'h0000_0000);
        wb(1'b0, `TCC_ADR_RATE, 32'h0);
        check(rd, 32'h0000_0006);
        wb(1'b0, `TCC_ADR_BETA, 32'h0);
        check(rd, 32'h000F_BDFF);
        wb(1'b0, 8'h3C, 32'h0);
        check(rd, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset
    task t_factor;
        logic [2:0] f;
        for (int k = 0; k < 32; k++) begin
            f = (k[3:0] == 4'hA) ? 3'h0 : k[4] ? 3'h1 : (k[3:0] > 4'h9 || k[3:0] < 4'h6) ? 3'h5 : 3'(10 - k[3:0]);
            wb(1'b1, `TCC_ADR_CTRL, 32'(k[4]) << 1);
            wb(1'b1, `TCC_ADR_RATE, 32'(k[3:0]));
            shot(11'h001);
            check(meas_factor, f);
            wb(1'b0, `TCC_ADR_STAT, 32'h0);
            check(rd, 32'h0000_0060 | (32'(f) << 2));
        end
        $display("test factor done");
    endtask : t_factor
    task t_rate;
        logic [3:0] code;
        int c;
        for (int k = 0; k < 4; k++) begin
            code = (k == 3) ? 4'hB : 4'(6 + k);
            wb(1'b1, `TCC_ADR_RATE, 32'(code));
            wb(1'b1, `TCC_ADR_CTRL, 32'h0000_0001);
            check(active, 1'b1);
            wait_ch0();
            wb(1'b1, `TCC_ADR_SHOT, 32'h0000_0001);
            wait_ch0();
            c = 0;
            do begin
                @(posedge clock);
                c++;
            end while (!(conv_start === 1'b1 && meas_chan === 2'h0));
            check(c, TICK * ((code > 4'hA) ? 64 : (1024 >> code)));
            wb(1'b1, `TCC_ADR_CTRL, 32'h0);
            check(active, 1'b0);
            while (busy !== 1'b0) @(posedge clock);
        end
        $display("test rate done");
    endtask : t_rate
    task t_filter;
        static logic [10:0] v[6] = '{11'h064, 11'h0C8, 11'h0C8, 11'h12C, 11'h000, 11'h007};
        static logic [10:0] e[6] = '{11'h064, 11'h07D, 11'h096, 11'h12C, 11'h106, 11'h007};
        for (int i = 0; i < 6; i++) begin
            if (i == 0) wb(1'b1, `TCC_ADR_CTRL, 32'h0000_0018);
            if (i == 3) wb(1'b1, `TCC_ADR_CTRL, 32'h0000_00BC);
            if (i == 5) wb(1'b1, `TCC_ADR_CTRL, 32'h0000_0080);
            shot(v[i]);
            check(result[0], e[i]);
            check(result[1], (i < 3) ? e[i] : v[i]);
            check(result[2], v[i]);
            wb(1'b0, `TCC_ADR_RES0, 32'h0);
            check(rd, 32'(e[i]));
        end
        $display("test filter done");
    endtask : t_filter
    task t_beta;
        shot(11'h001);
        check(seen_beta, 16'h5FF5);
        wb(1'b0, `TCC_ADR_BETA, 32'h0);
        check(rd, 32'h000A_BDF5);
        wb(1'b1, `TCC_ADR_BETA, 32'h0002_0243);
        shot(11'h001);
        check(seen_beta, 16'h4FF3);
        wb(1'b0, `TCC_ADR_BETA, 32'h0);
        check(rd, 32'h0002_3DE3);
        wb(1'b1, `TCC_ADR_BETA, 32'h0000_000F);
        shot(11'h001);
        check(seen_beta, 16'h0FFF);
        $display("test beta done");
    endtask : t_beta

    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        t_factor();
        t_rate();
        t_filter();
        t_beta();
        give_verdict();
    end
endmodule : tb_top

`default_nettype wire
